// ===== core/awdc_pkg.sv
// shared widths, encodings and carrier types for the write data channel
package awdc_pkg;

	localparam int DATA_W   = 128;
	localparam int STRB_W   = DATA_W / 8;
	localparam int TAG_W    = (DATA_W / 128 * 4 < 4) ? 4 : DATA_W / 128 * 4;
	localparam int UPD_W    = TAG_W / 4;
	localparam int USER_W   = 4;
	localparam int ID_W     = 4;
	localparam int LEN_W    = 8;
	localparam bit TRACE_EN = 1'b1;

	localparam logic [1:0] TAGOP_INVALID  = 2'h0;
	localparam logic [1:0] TAGOP_TRANSFER = 2'h1;
	localparam logic [1:0] TAGOP_UPDATE   = 2'h2;
	localparam logic [1:0] TAGOP_MATCH    = 2'h3;

	localparam logic [LEN_W-1:0] REMAIN_RST = 8'h00;
	localparam logic [ID_W-1:0]  ID_RST     = 4'h0;

	typedef struct packed {
		logic [ID_W-1:0]  id;
		logic [LEN_W-1:0] len;
		logic [1:0]       tagOp;
		logic [UPD_W-1:0] container;
	} awdc_cmd_type;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [STRB_W-1:0] strb;
		logic [USER_W-1:0] user;
		logic              trace;
		logic [TAG_W-1:0]  tag;
		logic [UPD_W-1:0]  tagUpdate;
	} awdc_beat_type;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [STRB_W-1:0] strb;
		logic              last;
		logic [USER_W-1:0] user;
		logic              trace;
		logic [TAG_W-1:0]  tag;
		logic [UPD_W-1:0]  tagUpdate;
	} awdc_wchan_type;

endpackage : awdc_pkg

// ===== core/awdc_tag_gate.sv
// per-nibble gating of the tag update mask
`timescale 1ns/100ps
module awdc_tag_gate
	import awdc_pkg::*;
(
	input  wire logic [1:0]       tagOp,
	input  wire logic [UPD_W-1:0] container,
	input  wire logic [UPD_W-1:0] rawUpdate,
	output logic      [UPD_W-1:0] gatedUpdate
);

	genvar i;
	generate
		for (i = 0; i < UPD_W; i++)
		begin : g_nib
			// bit i qualifies tag nibble i only
			assign gatedUpdate[i] = (tagOp == TAGOP_UPDATE)
				& container[i] & rawUpdate[i];
		end
	endgenerate

endmodule : awdc_tag_gate

// ===== core/awdc_write_channel.sv
// manager-side write data channel: one burst at a time, registered channel outputs (beatReady follows wReady combinationally)
`timescale 1ns/100ps
module awdc_write_channel
	import awdc_pkg::*;
(
	input  wire logic           clk,
	input  wire logic           reset,
	input  wire awdc_cmd_type   cmd,
	input  wire logic           cmdValid,
	output logic                cmdReady,
	input  wire awdc_beat_type  beat,
	input  wire logic           beatValid,
	output logic                beatReady,
	output awdc_wchan_type      wOut,
	output logic [ID_W-1:0]     wId,
	output logic                wValid,
	input  wire logic           wReady
);

	typedef enum logic {ST_IDLE, ST_BURST} awdc_state_type;

	awdc_state_type    state_q;
	logic [LEN_W-1:0]  remain_q;
	logic [ID_W-1:0]   id_q;
	logic [1:0]        tagOp_q;
	logic [UPD_W-1:0]  container_q;
	logic [1:0]        tagOpOut_q;
	logic [UPD_W-1:0]  containerOut_q;
	awdc_wchan_type    wOut_q;
	logic [ID_W-1:0]   wId_q;
	logic              wValid_q;
	logic [UPD_W-1:0]  gatedUpdate;
	logic              cmdFire;
	logic              beatFire;
	logic              wFire;
	logic              lastBeat;

	// a new command only while no burst is open
	assign cmdReady  = (state_q == ST_IDLE);
	// beats only inside a burst, and only when the output slot frees
	assign beatReady = (state_q == ST_BURST)
		&& (!wValid_q || wReady);
	assign cmdFire   = cmdValid && cmdReady;
	assign beatFire  = beatValid && beatReady;
	assign wFire     = wValid_q && wReady;
	assign lastBeat  = (remain_q == REMAIN_RST);

	assign wOut   = wOut_q;
	assign wId    = wId_q;
	assign wValid = wValid_q;

	awdc_tag_gate u_gate (
		.tagOp       (tagOp_q),
		.container   (container_q),
		.rawUpdate   (beat.tagUpdate),
		.gatedUpdate (gatedUpdate)
	);

	// burst sequencing
	always_ff @(posedge clk)
	begin
		if (reset)
			state_q <= ST_IDLE;
		else
		begin
			case (state_q)
				ST_IDLE:
					if (cmdFire)
						state_q <= ST_BURST;
				ST_BURST:
					if (beatFire && lastBeat)
						state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// burst attributes captured with the command
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			remain_q    <= REMAIN_RST;
			id_q        <= ID_RST;
			tagOp_q     <= TAGOP_INVALID;
			container_q <= '0;
		end
		else if (cmdFire)
		begin
			remain_q    <= cmd.len;
			id_q        <= cmd.id;
			tagOp_q     <= cmd.tagOp;
			container_q <= cmd.container;
		end
		else if (beatFire && !lastBeat)
			remain_q <= remain_q - 8'h01;
	end

	// output slot: loads on accepted beat, frozen while waiting for ready
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wOut_q         <= '0;
			wId_q          <= ID_RST;
			tagOpOut_q     <= TAGOP_INVALID;
			containerOut_q <= '0;
		end
		else if (beatFire)
		begin
			wOut_q.data      <= beat.data;
			wOut_q.strb      <= beat.strb;
			wOut_q.last      <= lastBeat;
			wOut_q.user      <= beat.user;
			wOut_q.trace     <= beat.trace & TRACE_EN;
			wOut_q.tag       <= beat.tag;
			wOut_q.tagUpdate <= gatedUpdate;
			wId_q            <= id_q;
			tagOpOut_q       <= tagOp_q;
			containerOut_q   <= container_q;
		end
	end

	// valid rises with a loaded beat and falls only on handshake
	always_ff @(posedge clk)
	begin
		if (reset)
			wValid_q <= 1'b0;
		else if (beatFire)
			wValid_q <= 1'b1;
		else if (wFire)
			wValid_q <= 1'b0;
	end

	// independent up-count of accepted beats, for the last-flag check
	logic [LEN_W-1:0]  lenChk_q;
	logic [LEN_W-1:0]  beatCnt_q;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			lenChk_q  <= REMAIN_RST;
			beatCnt_q <= REMAIN_RST;
		end
		else if (cmdFire)
		begin
			lenChk_q  <= cmd.len;
			beatCnt_q <= REMAIN_RST;
		end
		else if (beatFire)
			beatCnt_q <= beatCnt_q + 8'h01;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_stall;
		wValid && !wReady;
	endsequence

	property p_valid_held;
		s_stall |=> wValid;
	endproperty
	a_valid_held: assert property (p_valid_held)
		else $error("valid dropped before handshake");

	property p_hold_stable;
		s_stall |=> $stable(wOut) && $stable(wId);
	endproperty
	a_hold_stable: assert property (p_hold_stable)
		else $error("channel outputs changed while stalled");

	property p_tag_stable;
		s_stall ##1 s_stall |=> $stable(wOut.tag);
	endproperty
	a_tag_stable: assert property (p_tag_stable)
		else $error("tag changed while stalled");

	property p_last_flag;
		beatFire |=> wValid
			&& (wOut.last == $past(beatCnt_q == lenChk_q));
	endproperty
	a_last_flag: assert property (p_last_flag)
		else $error("last flag does not match beat count");

	property p_no_interleave;
		wFire && !wOut.last |-> state_q == ST_BURST && wId == id_q;
	endproperty
	a_no_interleave: assert property (p_no_interleave)
		else $error("burst left open while another started");

	property p_idle_blocks;
		state_q == ST_IDLE |-> !beatReady ##1 (state_q == ST_BURST
			|| !beatReady);
	endproperty
	a_idle_blocks: assert property (p_idle_blocks)
		else $error("beat accepted outside a burst");

	property p_update_op;
		wValid && tagOpOut_q != TAGOP_UPDATE |-> wOut.tagUpdate == '0;
	endproperty
	a_update_op: assert property (p_update_op)
		else $error("tag update set for non-update operation");

	property p_update_container;
		wValid |-> (wOut.tagUpdate & ~containerOut_q) == '0;
	endproperty
	a_update_container: assert property (p_update_container)
		else $error("tag update set outside container");

	property p_trace_off;
		wValid |-> (wOut.trace & ~TRACE_EN) == 1'b0;
	endproperty
	a_trace_off: assert property (p_trace_off)
		else $error("trace driven while not configured");

endmodule : awdc_write_channel

// ===== verification/awdc_sub_model.sv
// subordinate model answering the write data channel
`timescale 1ns/100ps
module awdc_sub_model
	import awdc_pkg::*;
(
	input  wire logic           clk,
	input  wire logic           reset,
	input  wire awdc_wchan_type wOut,
	input  wire logic           wValid,
	input  wire logic           slow,
	output logic                wReady,
	output logic [TAG_W-1:0]    tagMem_q
);
	always_ff @(posedge clk)
	begin
		if (reset)
			wReady <= 1'b0;
		else
			wReady <= slow ? ~wReady : 1'b1;
	end
	always_ff @(posedge clk)
	begin
		if (reset)
			tagMem_q <= '0;
		else if (wValid && wReady && wOut.tagUpdate[0])
			tagMem_q <= wOut.tag;
	end
endmodule : awdc_sub_model

// ===== verification/tb.sv
// self-checking bench for the write data channel
`timescale 1ns/100ps
module tb
	import awdc_pkg::*;
;
	logic           clk, reset, cmdValid, beatValid, wReady;
	logic           cmdReady, beatReady, wValid, slow;
	awdc_cmd_type   cmd;
	awdc_beat_type  beat;
	awdc_wchan_type wOut, got[16];
	logic [ID_W-1:0]  wId, gid[16];
	logic [TAG_W-1:0] tagMem;
	int             n = 0, mismatches = 0, checks = 0;

	awdc_write_channel i_awdc_write_channel (.clk(clk), .reset(reset),
		.cmd(cmd), .cmdValid(cmdValid), .cmdReady(cmdReady), .beat(beat),
		.beatValid(beatValid), .beatReady(beatReady), .wOut(wOut),
		.wId(wId), .wValid(wValid), .wReady(wReady));
	awdc_sub_model i_awdc_sub_model (.clk(clk), .reset(reset),
		.wOut(wOut), .wValid(wValid), .slow(slow), .wReady(wReady),
		.tagMem_q(tagMem));

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// capture every beat handed over
	always @(posedge clk)
	begin
		if (wValid && wReady)
		begin
			got[n] <= wOut;
			gid[n] <= wId;
			n <= n + 1;
		end
	end

	task automatic cmp(input logic [127:0] g, input logic [127:0] e);
		checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp

	task automatic run(input logic [3:0] id, input logic [7:0] len,
		input logic [1:0] op, input logic c);
		int k, base;
		awdc_wchan_type g;
		@(negedge clk);
		base = n;
		cmd = '{id, len, op, c};
		cmdValid = 1'b1;
		while (cmdReady !== 1'b1)
			@(negedge clk);
		@(negedge clk);
		cmdValid = 1'b0;
		for (int i = 0; i <= len; i++)
		begin
			beat = '{{124'h0, id}, 16'hffff >> i, i[3:0], 1'b1, i[3:0], 1'b1};
			beatValid = 1'b1;
			while (beatReady !== 1'b1)
				@(negedge clk);
			@(negedge clk);
		end
		beatValid = 1'b0;
		k = 0;
		while (n - base <= len && k < 50)
		begin
			@(negedge clk);
			k++;
		end
		cmp(n - base, len + 1);
		for (int i = 0; i <= len; i++)
		begin
			g = got[base + i];
			cmp(g.data, {124'h0, id});
			cmp(gid[base + i], id);
			cmp(g.strb, 16'hffff >> i);
			cmp(g.last, i == len);
			cmp(g.user, i[3:0]);
			cmp(g.trace, TRACE_EN);
			cmp(g.tag, i[3:0]);
			cmp(g.tagUpdate, op == TAGOP_UPDATE && c);
		end
	endtask : run

	task automatic t_update();
		run(4'h3, 8'h3, TAGOP_UPDATE, 1'b1);
		cmp(tagMem, 4'h3);
		$display("update burst done");
	endtask : t_update

	task automatic t_ops();
		for (int op = 0; op < 4; op++)
			run(op[3:0], 8'h0, op[1:0], 1'b1);
		$display("tag operations done");
	endtask : t_ops

	task automatic t_container();
		run(4'h5, 8'h1, TAGOP_UPDATE, 1'b0);
		cmp(tagMem, 4'h0);
		$display("container done");
	endtask : t_container

	task automatic t_stall();
		slow = 1'b1;
		run(4'h9, 8'h4, TAGOP_UPDATE, 1'b1);
		cmp(tagMem, 4'h4);
		slow = 1'b0;
		$display("stalled burst done");
	endtask : t_stall

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude

	initial
	begin
		#20000;
		mismatches++;
		conclude();
	end

	initial
	begin
		reset = 1'b1;
		cmdValid = 1'b0;
		beatValid = 1'b0;
		slow = 1'b0;
		cmd = '0;
		beat = '0;
		repeat (8) @(negedge clk);
		reset = 1'b0;
		t_update();
		t_ops();
		t_container();
		t_stall();
		conclude();
	end
endmodule : tb
